//--- hw/ioport_regs.svh
`ifndef IOPORT_REGS_SVH
`define IOPORT_REGS_SVH
// ====================================================================
// io window
`define IOP_BASE_RST 10'h300
`define IOP_WIN_LSB 5
`define IOP_PORT_BIT 4
// ====================================================================
// internal memory map
`define IOP_RAM_BIT 14
`define IOP_RAM_WORDS 8192
`define IOP_STORE_BYTES 16
`define IOP_SIG_IDX 4'hE
`define IOP_SIG_WIDE 8'h57
`define IOP_SIG_NARROW 8'h42
// ====================================================================
// eeprom load
`define IOP_EE_LAST 3'h7
`define IOP_LOAD_US 320
`define IOP_CLK_MHZ 200
`endif

//--- hw/ioport_pkg.sv
package ioport_pkg;
    typedef enum logic [1:0]
    {
        ST_RESET = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } ldst_t;
endpackage : ioport_pkg

//--- hw/xfer_fifo.sv
`timescale 1ns/1ps
module xfer_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;
    always_comb
    begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (AW + 1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem[wp_r] <= in_data_i;
        end
    end
    assign in_ready_o = (cnt_r != (AW + 1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem[rp_r];
endmodule : xfer_fifo

//--- hw/isa_io_port_remote_dma.sv
// Operation
// - strap sampled during reset picks bus width
// - strap high is 16-bit, low is 8-bit
// - window decoded at loadable io base
// - control registers 8-bit, data port 16-bit
// - one byte or word per port access
// - 64k internal space, partially decoded, aliased
// - store below 4000h, ram above, repeats
// - read of empty port stretches with chrdy
// - next fetch waits for previous word read
// - write into full port stretches with chrdy
// - next memory write waits for new word
// - address store loaded from serial eeprom
// - 16-bit store reads give zero upper byte
// - station address in ascending low entries
// - top entries read 57h wide, 42h narrow
// - narrow mode reaches only 8 kbytes ram
// - narrow odd store addresses mirror even ones
// - io layout same in both widths
// - first eight eeprom words copied after reset
// - device inaccessible during eeprom load
`timescale 1ns/1ps
`include "ioport_regs.svh"
module isa_io_port_remote_dma
    import ioport_pkg::*;
#(
    parameter int LOAD_CYCLES = `IOP_LOAD_US * `IOP_CLK_MHZ,
    parameter int RAM_WORDS = `IOP_RAM_WORDS
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic isa_reset_i,
    input wire logic width_strap_pin_i,
    input wire logic aen_i,
    input wire logic ior_n_i,
    input wire logic iow_n_i,
    input wire logic [9:0] sa_i,
    input wire logic [15:0] sd_i,
    output logic [15:0] sd_o,
    output logic sd_oe_o,
    output logic chrdy_oe_o,
    input wire logic io_base_we_i,
    input wire logic [9:0] io_base_i,
    output logic reg_wr_o,
    output logic [3:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic rdma_start_i,
    input wire logic rdma_write_i,
    input wire logic [15:0] rdma_addr_i,
    input wire logic [15:0] rdma_count_i,
    output logic rdma_busy_o,
    output logic ee_req_o,
    output logic [2:0] ee_word_o,
    input wire logic ee_ack_i,
    input wire logic [15:0] ee_data_i,
    output logic wide_mode_o,
    output logic ready_o
);
    localparam logic [16:0] LOAD_LAST = 17'(LOAD_CYCLES - 1);
    // ====================================================================
    // pin synchronisers
    // strobes, address and data share one delay line, so they stay aligned
    logic [30:0] pin_s1, pin_s2;
    logic ior_q, iow_q;
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_s1 <= {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 26'h000_0000};
            pin_s2 <= {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 26'h000_0000};
            ior_q <= 1'b1;
            iow_q <= 1'b1;
        end
        else
        begin
            pin_s1 <= {isa_reset_i, width_strap_pin_i, aen_i, ior_n_i, iow_n_i, sa_i[9:1], sa_i[0], sd_i};
            pin_s2 <= pin_s1;
            ior_q <= pin_s2[27];
            iow_q <= pin_s2[26];
        end
    end
    logic rst_s, strap_s, aen_s, ior_s, iow_s;
    logic [9:0] sa_s;
    logic [15:0] sd_s;
    assign {rst_s, strap_s, aen_s, ior_s, iow_s, sa_s, sd_s} = pin_s2;
    // ====================================================================
    // state
    ldst_t st_r, st_nxt;
    logic wide_r, wide_nxt, ready_r, ready_nxt, ee_req_r, ee_req_nxt;
    logic [2:0] ee_idx_r, ee_idx_nxt;
    logic [16:0] tmr_r, tmr_nxt;
    logic [9:0] base_r, base_nxt;
    logic [15:0] sd_out_r, sd_out_nxt, port_r, port_nxt, wcap_r, wcap_nxt;
    logic sd_oe_r, sd_oe_nxt, chrdy_r, chrdy_nxt, pvalid_r, pvalid_nxt;
    logic rd_port_r, rd_port_nxt, wr_port_r, wr_port_nxt, wr_reg_r, wr_reg_nxt;
    logic reg_wr_r, reg_wr_nxt;
    logic [3:0] wofs_r, wofs_nxt;
    logic [15:0] addr_r, addr_nxt, cnt_r, cnt_nxt;
    logic busy_r, busy_nxt, dir_r, dir_nxt;
    logic [7:0] store_r [`IOP_STORE_BYTES];
    logic [15:0] ram [RAM_WORDS];
    logic store_we, ram_we_lo, ram_we_hi;
    logic [12:0] ram_idx;
    logic [15:0] ram_wd, mem_rd, step;
    logic hit, port, fetch, put;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [15:0] fifo_out_data;

    // top two entries answer the width signature, not the loaded bytes
    function automatic logic [7:0] store_byte(input logic [3:0] idx, input logic wide);
        if (idx >= `IOP_SIG_IDX)
            return wide ? `IOP_SIG_WIDE : `IOP_SIG_NARROW;
        return store_r[idx];
    endfunction : store_byte

    xfer_fifo #(.WIDTH(16), .DEPTH(16)) u_wfifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wcap_r),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ====================================================================
    // next values
    always_comb
    begin
        st_nxt = st_r;
        {wide_nxt, ee_req_nxt, ee_idx_nxt, tmr_nxt} = {wide_r, ee_req_r, ee_idx_r, tmr_r};
        base_nxt = io_base_we_i ? io_base_i : base_r;
        store_we = 1'b0;
        case (st_r)
            ST_RESET:
            begin
                wide_nxt = strap_s;
                if (!rst_s)
                begin
                    st_nxt = ST_LOAD;
                    ee_idx_nxt = 3'h0;
                    tmr_nxt = 17'h0_0000;
                    ee_req_nxt = 1'b1;
                end
            end
            ST_LOAD:
            begin
                tmr_nxt = 17'(tmr_r + 1'b1);
                store_we = ee_req_r && ee_ack_i;
                if (store_we)
                    ee_idx_nxt = 3'(ee_idx_r + 1'b1);
                if ((store_we && ee_idx_r == `IOP_EE_LAST) || tmr_r == LOAD_LAST)
                begin
                    st_nxt = ST_RUN;
                    ee_req_nxt = 1'b0;
                end
            end
            ST_RUN:
                st_nxt = ST_RUN;
            default:
                st_nxt = ST_RESET;
        endcase
        if (rst_s)
        begin
            st_nxt = ST_RESET;
            ee_req_nxt = 1'b0;
        end
        ready_nxt = (st_nxt == ST_RUN);
        // window ignored until load is over; same layout in both widths
        hit = !aen_s && sa_s[9:`IOP_WIN_LSB] == base_r[9:`IOP_WIN_LSB] && st_r == ST_RUN;
        port = sa_s[`IOP_PORT_BIT];
        rd_port_nxt = !ior_s ? (hit && port) : rd_port_r;
        sd_oe_nxt = !ior_s && hit && (!port || pvalid_r);
        sd_out_nxt = port ? port_r : {8'h00, reg_rdata_i};
        chrdy_nxt = hit && port && busy_r && ((!ior_s && !pvalid_r && !dir_r) || (!iow_s && !fifo_in_ready));
        {wcap_nxt, wr_port_nxt, wr_reg_nxt, wofs_nxt} = {wcap_r, wr_port_r, wr_reg_r, wofs_r};
        if (!iow_s && hit)
            {wcap_nxt, wr_port_nxt, wr_reg_nxt, wofs_nxt} = {sd_s, port, !port, sa_s[3:0]};
        fifo_in_valid = 1'b0;
        reg_wr_nxt = 1'b0;
        if (iow_s && !iow_q)
        begin
            fifo_in_valid = wr_port_r && busy_r && dir_r;
            reg_wr_nxt = wr_reg_r;
            wr_port_nxt = 1'b0;
            wr_reg_nxt = 1'b0;
        end
        pvalid_nxt = pvalid_r;
        if (ior_s && !ior_q && rd_port_r)
        begin
            pvalid_nxt = 1'b0;
            rd_port_nxt = 1'b0;
        end
        // dma engine; memory only through here
        step = wide_r ? 16'h0002 : 16'h0001;
        {addr_nxt, cnt_nxt, busy_nxt, dir_nxt, port_nxt} = {addr_r, cnt_r, busy_r, dir_r, port_r};
        ram_idx = wide_r ? addr_r[13:1] : {1'b0, addr_r[12:1]};
        if (addr_r[`IOP_RAM_BIT])
            mem_rd = wide_r ? ram[ram_idx] : {8'h00, addr_r[0] ? ram[ram_idx][15:8] : ram[ram_idx][7:0]};
        else
            mem_rd = {8'h00, store_byte(addr_r[4:1], wide_r)};
        // a read already waiting on an empty port must not block the fetch that ends its wait
        fetch = busy_r && !dir_r && !pvalid_r;
        put = busy_r && dir_r && fifo_out_valid;
        fifo_out_ready = put;
        ram_wd = wide_r ? fifo_out_data : {fifo_out_data[7:0], fifo_out_data[7:0]};
        ram_we_lo = put && addr_r[`IOP_RAM_BIT] && (wide_r || !addr_r[0]);
        ram_we_hi = put && addr_r[`IOP_RAM_BIT] && (wide_r || addr_r[0]);
        if (fetch)
        begin
            port_nxt = mem_rd;
            pvalid_nxt = 1'b1;
        end
        if (fetch || put)
        begin
            addr_nxt = 16'(addr_r + step);
            cnt_nxt = (cnt_r > step) ? 16'(cnt_r - step) : 16'h0000;
            busy_nxt = (cnt_r > step);
        end
        if (rdma_start_i)
        begin
            {addr_nxt, cnt_nxt, dir_nxt} = {rdma_addr_i, rdma_count_i, rdma_write_i};
            busy_nxt = (rdma_count_i != 16'h0000);
            pvalid_nxt = 1'b0;
        end
    end

    // ====================================================================
    // registers
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r <= ST_RESET;
            {wide_r, ready_r, ee_req_r, ee_idx_r, tmr_r} <= {1'b0, 1'b0, 1'b0, 3'h0, 17'h0_0000};
            base_r <= `IOP_BASE_RST;
            {sd_out_r, sd_oe_r, chrdy_r, port_r, pvalid_r, rd_port_r} <= '0;
            {wcap_r, wr_port_r, wr_reg_r, wofs_r, reg_wr_r} <= '0;
            {addr_r, cnt_r, busy_r, dir_r} <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            {wide_r, ready_r, ee_req_r, ee_idx_r, tmr_r} <= {wide_nxt, ready_nxt, ee_req_nxt, ee_idx_nxt, tmr_nxt};
            base_r <= base_nxt;
            {sd_out_r, sd_oe_r, chrdy_r, port_r, pvalid_r, rd_port_r} <=
                {sd_out_nxt, sd_oe_nxt, chrdy_nxt, port_nxt, pvalid_nxt, rd_port_nxt};
            {wcap_r, wr_port_r, wr_reg_r, wofs_r, reg_wr_r} <= {wcap_nxt, wr_port_nxt, wr_reg_nxt, wofs_nxt, reg_wr_nxt};
            {addr_r, cnt_r, busy_r, dir_r} <= {addr_nxt, cnt_nxt, busy_nxt, dir_nxt};
        end
    end
    // storage arrays carry no reset; they are filled before use
    always_ff @(posedge clock_i)
    begin
        if (store_we)
        begin
            store_r[{ee_idx_r, 1'b0}] <= ee_data_i[7:0];
            store_r[{ee_idx_r, 1'b1}] <= ee_data_i[15:8];
        end
        if (ram_we_lo)
            ram[ram_idx][7:0] <= ram_wd[7:0];
        if (ram_we_hi)
            ram[ram_idx][15:8] <= ram_wd[15:8];
    end
    assign {sd_o, sd_oe_o, chrdy_oe_o} = {sd_out_r, sd_oe_r, chrdy_r};
    assign {reg_wr_o, reg_addr_o, reg_wdata_o} = {reg_wr_r, wofs_r, wcap_r[7:0]};
    assign {rdma_busy_o, ee_req_o, ee_word_o, wide_mode_o, ready_o} = {busy_r, ee_req_r, ee_idx_r, wide_r, ready_r};

    // ====================================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    width_hold_a: assert property (st_r == ST_RUN && !rst_s |=> $stable(wide_r))
        else $error("width changed outside reset");
    rd_stretch_a: assert property (!ior_s && hit && port && busy_r && !dir_r && !pvalid_r |=> chrdy_oe_o)
        else $error("empty port read not stretched");
    wr_stretch_a: assert property (!iow_s && hit && port && busy_r && !fifo_in_ready |=> chrdy_oe_o)
        else $error("full port write not stretched");
    no_prefetch_a: assert property (pvalid_r && !dir_r && !rdma_start_i |=> $stable(addr_r))
        else $error("fetch before port read");
    wr_wait_a: assert property (dir_r && !fifo_out_valid && !rdma_start_i |=> $stable(addr_r))
        else $error("memory write without new word");
    upper_zero_a: assert property (fetch && wide_r && !addr_r[`IOP_RAM_BIT] |=> port_r[15:8] == 8'h00)
        else $error("store upper byte not zero");
    signature_a: assert property (fetch && addr_r[4:1] >= `IOP_SIG_IDX && !addr_r[`IOP_RAM_BIT]
        |=> port_r[7:0] == (wide_r ? 8'h57 : 8'h42))
        else $error("wrong width signature");
    addr_step_a: assert property ((fetch || put) && !rdma_start_i |=> addr_r == 16'($past(addr_r) + (wide_r ? 2 : 1)))
        else $error("dma address step wrong");
    drive_own_a: assert property (sd_oe_o |-> $past(!ior_s && hit))
        else $error("bus driven outside own read");
    load_quiet_a: assert property (st_r != ST_RUN |=> !sd_oe_o ##1 !sd_oe_o)
        else $error("bus driven during load");
    load_nostall_a: assert property (!ready_r |=> !chrdy_oe_o)
        else $error("wait state during load");
    narrow_ram_a: assert property (!wide_r && (ram_we_lo || ram_we_hi) |-> !ram_idx[12])
        else $error("narrow ram index out of range");
    store_ro_a: assert property (put && !addr_r[`IOP_RAM_BIT] |-> !ram_we_lo && !ram_we_hi)
        else $error("write reached address store");
endmodule : isa_io_port_remote_dma

//--- verif/ee_model.sv
`timescale 1ns/1ps
// ====================================================================
// serial eeprom stand-in: answers each word request, prompt or slow
module ee_model (
    input wire logic clock_i,
    input wire logic ee_req_i,
    input wire logic [2:0] ee_word_i,
    output logic ee_ack_o,
    output logic [15:0] ee_data_o
);
    logic [15:0] last_r;
    int n;
    initial
    begin
        ee_ack_o = 1'b0;
        ee_data_o = 16'h0000;
        n = 0;
        forever
        begin
            @(posedge clock_i);
            #1;
            if (ee_req_i === 1'b1)
            begin
                repeat ((n % 2) ? 6 : 1) @(posedge clock_i);
                #1;
                // low byte 0xa0 + 2i, high byte 0xa1 + 2i; last word holds the width signature
                last_r = (ee_word_i == 3'h7) ? 16'h5757 : {4'hA, ee_word_i, 1'b1, 4'hA, ee_word_i, 1'b0};
                ee_data_o = last_r;
                ee_ack_o = 1'b1;
                @(posedge clock_i);
                #1;
                ee_ack_o = 1'b0;
                // data is not held after the ack, so show a different value
                ee_data_o = ~last_r;
                n++;
            end
        end
    end
endmodule : ee_model

//--- verif/isa_io_port_remote_dma_bench.sv
`timescale 1ns/1ps
module isa_io_port_remote_dma_bench;
    logic clock_i, resetn_i, isa_reset_i, width_strap_pin_i, aen_i, ior_n_i, iow_n_i, io_base_we_i;
    logic rdma_start_i, rdma_write_i, ee_ack_i, sd_oe_o, chrdy_oe_o, reg_wr_o, rdma_busy_o;
    logic ee_req_o, wide_mode_o, ready_o;
    logic [9:0] sa_i, io_base_i;
    logic [15:0] sd_i, sd_o, rdma_addr_i, rdma_count_i, ee_data_i;
    logic [7:0] reg_wdata_o, reg_rdata_i, wr_data_r;
    logic [3:0] reg_addr_o, wr_addr_r;
    logic [2:0] ee_word_o;
    int errors, cmp_count;
    // ====================================================================
    // design and eeprom model
    isa_io_port_remote_dma #(.LOAD_CYCLES(500)) dut_u (.clock_i, .resetn_i, .isa_reset_i, .width_strap_pin_i,
        .aen_i, .ior_n_i, .iow_n_i, .sa_i, .sd_i, .sd_o, .sd_oe_o, .chrdy_oe_o, .io_base_we_i, .io_base_i,
        .reg_wr_o, .reg_addr_o, .reg_wdata_o, .reg_rdata_i, .rdma_start_i, .rdma_write_i, .rdma_addr_i,
        .rdma_count_i, .rdma_busy_o, .ee_req_o, .ee_word_o, .ee_ack_i, .ee_data_i, .wide_mode_o, .ready_o);
    ee_model ee_u (.clock_i(clock_i), .ee_req_i(ee_req_o), .ee_word_i(ee_word_o), .ee_ack_o(ee_ack_i),
        .ee_data_o(ee_data_i));
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // the pulse is caught mid-cycle, away from the edge that launches it
    always @(negedge clock_i)
        if (reg_wr_o === 1'b1)
        begin
            wr_addr_r <= reg_addr_o;
            wr_data_r <= reg_wdata_o;
        end
    // ====================================================================
    // helpers
    task automatic tk(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tk
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] entry(input int k, input logic wide);
        if (k >= 14)
            return wide ? 8'h57 : 8'h42;
        return 8'hA0 + 8'(k);
    endfunction : entry
    // host read: strobe held until the port answers and chrdy is released
    task automatic io_rd(input logic [9:0] a, input int lim, output logic [15:0] d, output logic hit);
        int k;
        sa_i = a;
        ior_n_i = 1'b0;
        hit = 1'b0;
        for (k = 0; k < lim && !hit; k++)
        begin
            tk(1);
            hit = (sd_oe_o === 1'b1) && (chrdy_oe_o === 1'b0);
        end
        // data is taken while the strobe that asked for it still stands
        d = sd_o;
        ior_n_i = 1'b1;
        tk(6);
    endtask : io_rd
    task automatic io_wr(input logic [9:0] a, input logic [15:0] d);
        int k;
        sa_i = a;
        sd_i = d;
        iow_n_i = 1'b0;
        tk(4);
        for (k = 0; k < 400 && chrdy_oe_o !== 1'b0; k++)
            tk(1);
        iow_n_i = 1'b1;
        tk(6);
    endtask : io_wr
    task automatic dma(input logic wr, input logic [15:0] a, input logic [15:0] n);
        int k;
        rdma_write_i = wr;
        rdma_addr_i = a;
        rdma_count_i = n;
        rdma_start_i = 1'b1;
        tk(1);
        rdma_start_i = 1'b0;
        tk(2);
        for (k = 0; k < 400 && wr && rdma_busy_o !== 1'b0 && n == 16'h0000; k++)
            tk(1);
    endtask : dma
    task automatic wait_idle;
        int k;
        for (k = 0; k < 500 && rdma_busy_o !== 1'b0; k++)
            tk(1);
        check("rdma_busy_o", {15'h0, rdma_busy_o}, 16'h0000);
    endtask : wait_idle
    task automatic do_reset(input logic strap);
        int k;
        resetn_i = 1'b0;
        isa_reset_i = 1'b1;
        width_strap_pin_i = strap;
        tk(3);
        resetn_i = 1'b1;
        tk(4);
        isa_reset_i = 1'b0;
        tk(2);
        check("ready_o", {15'h0, ready_o}, 16'h0000);
        for (k = 0; k < 2000 && ready_o !== 1'b1; k++)
            tk(1);
        check("ready_o", {15'h0, ready_o}, 16'h0001);
        // strap only counts while reset is held
        width_strap_pin_i = ~strap;
        tk(5);
        check("wide_mode_o", {15'h0, wide_mode_o}, {15'h0, strap});
    endtask : do_reset
    // ====================================================================
    // scenarios
    task automatic t_store_wide;
        logic [15:0] d;
        logic hit;
        dma(1'b0, 16'h0000, 16'h0020);
        for (int k = 0; k < 16; k++)
        begin
            io_rd(10'h310 + 10'(k), 400, d, hit);
            check("store word", d, {8'h00, entry(k, 1'b1)});
        end
        wait_idle();
        dma(1'b0, 16'hA004, 16'h0002);
        io_rd(10'h31F, 400, d, hit);
        check("alias word", d, {8'h00, entry(2, 1'b1)});
        $display("store read wide done");
    endtask : t_store_wide
    task automatic t_ram_wide;
        logic [15:0] d;
        logic hit;
        dma(1'b1, 16'h4000, 16'h0008);
        for (int k = 0; k < 4; k++)
            io_wr(10'h310, 16'h5A00 + 16'(k));
        wait_idle();
        dma(1'b0, 16'hC000, 16'h0008);
        for (int k = 0; k < 4; k++)
        begin
            io_rd(10'h310, 400, d, hit);
            check("ram word", d, 16'h5A00 + 16'(k));
        end
        $display("ram wide done");
    endtask : t_ram_wide
    task automatic t_regs;
        logic [15:0] d;
        logic hit;
        io_wr(10'h303, 16'h003C);
        check("reg_addr_o", {12'h0, wr_addr_r}, 16'h0003);
        check("reg_wdata_o", {8'h00, wr_data_r}, 16'h003C);
        io_base_i = 10'h200;
        io_base_we_i = 1'b1;
        tk(1);
        io_base_we_i = 1'b0;
        io_rd(10'h307, 20, d, hit);
        check("old base hit", {15'h0, hit}, 16'h0000);
        io_rd(10'h207, 20, d, hit);
        check("new base read", {8'h00, d[7:0]}, 16'h005A);
        aen_i = 1'b1;
        io_rd(10'h207, 20, d, hit);
        check("dma cycle hit", {15'h0, hit}, 16'h0000);
        aen_i = 1'b0;
        $display("registers done");
    endtask : t_regs
    task automatic t_narrow;
        logic [15:0] d;
        logic hit;
        dma(1'b0, 16'h0000, 16'h0004);
        for (int k = 0; k < 4; k++)
        begin
            io_rd(10'h310, 400, d, hit);
            check("narrow store", d, {8'h00, entry(k / 2, 1'b0)});
        end
        dma(1'b0, 16'h001C, 16'h0002);
        for (int k = 0; k < 2; k++)
        begin
            io_rd(10'h310, 400, d, hit);
            check("narrow signature", d, 16'h0042);
        end
        dma(1'b1, 16'h4000, 16'h0002);
        io_wr(10'h310, 16'h0011);
        io_wr(10'h310, 16'h0022);
        wait_idle();
        dma(1'b0, 16'h6000, 16'h0002);
        for (int k = 1; k < 3; k++)
        begin
            io_rd(10'h310, 400, d, hit);
            check("narrow ram", d, 16'h0011 * 16'(k));
        end
        $display("narrow mode done");
    endtask : t_narrow
    // host reads the port before the dma has fetched: chrdy must stall it for one word time
    task automatic t_stretch;
        logic [15:0] d;
        logic hit;
        sa_i = 10'h318;
        ior_n_i = 1'b0;
        tk(4);
        check("idle port oe", {15'h0, sd_oe_o}, 16'h0000);
        rdma_write_i = 1'b0;
        rdma_addr_i = 16'h4000;
        rdma_count_i = 16'h0004;
        rdma_start_i = 1'b1;
        tk(1);
        rdma_start_i = 1'b0;
        tk(1);
        check("empty port stall", {15'h0, chrdy_oe_o}, 16'h0001);
        tk(1);
        check("filled port oe", {15'h0, sd_oe_o}, 16'h0001);
        check("stalled read", sd_o, 16'h5A00);
        ior_n_i = 1'b1;
        tk(6);
        io_rd(10'h310, 400, d, hit);
        check("next word", d, 16'h5A01);
        wait_idle();
        $display("read stall done");
    endtask : t_stretch
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    // ====================================================================
    // main sequence and watchdog (about a hundred times the expected run)
    initial
    begin
        errors = 0;
        cmp_count = 0;
        {aen_i, io_base_we_i, rdma_start_i, rdma_write_i} = 4'h0;
        {ior_n_i, iow_n_i} = 2'b11;
        sa_i = 10'h000;
        sd_i = 16'h0000;
        io_base_i = 10'h300;
        rdma_addr_i = 16'h0000;
        rdma_count_i = 16'h0000;
        reg_rdata_i = 8'h5A;
        do_reset(1'b1);
        t_store_wide();
        t_ram_wide();
        t_stretch();
        t_regs();
        do_reset(1'b0);
        t_narrow();
        give_verdict();
    end
    initial
    begin
        #300000;
        errors++;
        give_verdict();
    end
endmodule : isa_io_port_remote_dma_bench
